// File: src/aspc_regs.svh
`ifndef ASPC_REGS_SVH
`define ASPC_REGS_SVH

// Register indices; byte address is four times the index
`define ASPC_IDX_MODE      16'hFF70
`define ASPC_IDX_BAUD      16'hFF71
`define ASPC_IDX_RXBUF     16'hFF72
`define ASPC_IDX_ERR       16'hFF73
`define ASPC_IDX_TXDATA    16'hFF74
`define ASPC_ADDR_MODE     {14'h0000, `ASPC_IDX_MODE, 2'h0}
`define ASPC_ADDR_BAUD     {14'h0000, `ASPC_IDX_BAUD, 2'h0}
`define ASPC_ADDR_RXBUF    {14'h0000, `ASPC_IDX_RXBUF, 2'h0}
`define ASPC_ADDR_ERR      {14'h0000, `ASPC_IDX_ERR, 2'h0}
`define ASPC_ADDR_TXDATA   {14'h0000, `ASPC_IDX_TXDATA, 2'h0}

// Mode control field positions
`define ASPC_BIT_POWER     7
`define ASPC_BIT_TXEN      6
`define ASPC_BIT_RXEN      5
`define ASPC_BIT_PAR_HI    4
`define ASPC_BIT_PAR_LO    3
`define ASPC_BIT_CLEN      2
`define ASPC_BIT_SLEN      1

// Error flag positions
`define ASPC_BIT_PERR      2
`define ASPC_BIT_FERR      1
`define ASPC_BIT_OVERR     0

// Reset values
`define ASPC_MODE_RST      8'h01
`define ASPC_ERR_RST       3'h0
`define ASPC_BUF_RST       8'hFF
`define ASPC_BAUD_RST      8'h1F

// Last base clock tick of a serial bit, and the tick that marks mid-bit
`define ASPC_TICK_LAST     4'hF
`define ASPC_TICK_HALF     4'h7

`endif

// File: src/aspc_pkg.sv
package aspc_pkg;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PAR,
    TX_STOP
  } aspc_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP
  } aspc_rx_state_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } aspc_par_mode_t;

endpackage

// File: src/aspc_core.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "aspc_regs.svh"
// Notes on behaviour
// - Holding buffer is 8 bits, loaded from receive shifter per complete character.
// - With 7-bit characters data sits in bits 0..6 and bit 7 reads zero.
// - On overrun the new character is dropped and the buffer is kept.
// - Holding buffer is read-only; reset and power-off set it to FFH.
// - Writing transmit data starts a frame on serial_out_pin; it is write-only.
// - Transmit data register is FFH on reset, power-off or transmit disabled.
// - Power-off stops the base clock, clears state and forces receive line high.
// - Clearing a direction enable resets that direction; enables sync to base clock.
// - Parity field: none, send zero/no check, odd, even.
// - Zero-parity reception never sets the parity error flag.
// - Character length bit: 0 gives 7 data bits, 1 gives 8.
// - Transmitter sends 1 or 2 stop bits; receiver checks only the first.
// - Enabling reception while the line is low starts a reception.
// - Error flags in bits 2..0, upper zero, cleared by read or by power-off alone.
// - Parity mismatch sets parity error; missing stop bit sets framing error.
// - Completion while the buffer is unread sets the overrun flag.
module aspc_core (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // Event pulses
  output logic             tx_done_irq,
  output logic             rx_done_irq,
  output logic             rx_err_irq
);

  // Parity bit for a character under the given length and mode
  function automatic logic par_bit(input logic [7:0] d, input logic len8,
                                   input logic [1:0] sel);
    logic [7:0] dm;
    dm = len8 ? d : {1'b0, d[6:0]};
    case (sel)
      2'h2:    par_bit = ~^dm;
      2'h3:    par_bit = ^dm;
      default: par_bit = 1'b0;
    endcase
  endfunction

  // Registers
  logic [7:0] uart_mode_control;
  logic [7:0] baud_gen_control;
  logic [2:0] rx_error_flags;
  logic [7:0] rx_holding_buffer;
  logic [7:0] tx_shift_data;
  logic       rx_full;

  // Base clock and synchronised enables
  logic [7:0] base_cnt;
  logic       base_tick;
  logic       tx_en_q;
  logic       rx_en_q;

  // Receive line synchroniser
  logic       rx_s1;
  logic       rx_s2;
  logic       rx_s3;
  logic       rx_line;

  // Transmitter state
  aspc_pkg::aspc_tx_state_t tx_state;
  logic [3:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;

  // Receiver state
  aspc_pkg::aspc_rx_state_t rx_state;
  logic [3:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_shifter;
  logic       rx_par;

  // Mode fields
  wire        power_enable_bit = uart_mode_control[`ASPC_BIT_POWER];
  wire        tx_enable_bit    = uart_mode_control[`ASPC_BIT_TXEN];
  wire        rx_enable_bit    = uart_mode_control[`ASPC_BIT_RXEN];
  wire  [1:0] parity_sel       = {uart_mode_control[`ASPC_BIT_PAR_HI],
                                  uart_mode_control[`ASPC_BIT_PAR_LO]};
  wire        char_length_sel  = uart_mode_control[`ASPC_BIT_CLEN];
  wire        stop_length_sel  = uart_mode_control[`ASPC_BIT_SLEN];
  wire  [2:0] last_data_bit    = char_length_sel ? 3'h7 : 3'h6;
  wire        par_on           = parity_sel != aspc_pkg::PAR_NONE;

  // Bus decode
  wire        setup_rd   = psel & ~penable & ~pwrite;
  wire        setup_cyc  = psel & ~penable;
  wire        acc        = psel & penable;
  wire        hit_mode   = paddr == `ASPC_ADDR_MODE;
  wire        hit_baud   = paddr == `ASPC_ADDR_BAUD;
  wire        hit_rxbuf  = paddr == `ASPC_ADDR_RXBUF;
  wire        hit_err    = paddr == `ASPC_ADDR_ERR;
  wire        hit_tx     = paddr == `ASPC_ADDR_TXDATA;
  wire        hit_any    = hit_mode | hit_baud | hit_rxbuf | hit_err | hit_tx;
  wire        wr_acc     = acc & pwrite & pstrb[0];
  wire        mode_wr    = wr_acc & hit_mode;
  wire        baud_wr    = wr_acc & hit_baud;
  wire        tx_wr      = wr_acc & hit_tx & tx_en_q & power_enable_bit;
  wire        err_rd     = acc & ~pwrite & hit_err;
  wire        rxb_rd     = acc & ~pwrite & hit_rxbuf;

  // Read mux; transmit data and unmapped space read as zero
  wire  [7:0] rd_mux     = hit_mode  ? uart_mode_control :
                           hit_baud  ? baud_gen_control :
                           hit_rxbuf ? rx_holding_buffer :
                           hit_err   ? {5'h00, rx_error_flags} :
                           8'h00;

  // Run conditions; power-off or a synced disable holds a direction in reset
  wire        tx_run     = power_enable_bit & tx_en_q;
  wire        rx_run     = power_enable_bit & rx_en_q;

  // Per-tick progress of the two shifters
  wire        tx_adv     = base_tick & (tx_cnt == `ASPC_TICK_LAST);
  wire        rx_mid     = base_tick & (rx_cnt == `ASPC_TICK_HALF);
  wire        rx_adv     = base_tick & (rx_cnt == `ASPC_TICK_LAST);

  // Receive completion and its checks
  wire        rx_done    = rx_run & (rx_state == aspc_pkg::RX_STOP) & rx_adv;
  wire  [7:0] rx_data    = char_length_sel ? rx_shifter
                                           : {1'b0, rx_shifter[7:1]};
  wire        perr       = parity_sel[1] &
                           (rx_par != par_bit(rx_data, char_length_sel,
                                              parity_sel));
  wire        ferr       = ~rx_line;
  wire        overrun    = rx_full & ~rxb_rd;
  wire  [2:0] err_set    = {perr, ferr, overrun} & {3{rx_done}};

  // APB handshake: zero wait states
  assign pready = 1'b1;

  // Read data and error captured in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      if (setup_rd) begin
        prdata <= {24'h000000, rd_mux};
      end
      if (setup_cyc) begin
        pslverr <= ~hit_any;
      end
    end
  end

  // Mode control; bit 0 always reads as one
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      uart_mode_control <= `ASPC_MODE_RST;
    end else if (mode_wr) begin
      uart_mode_control <= {pwdata[7:1], 1'b1};
    end
  end

  // Base clock divider register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      baud_gen_control <= `ASPC_BAUD_RST;
    end else if (baud_wr) begin
      baud_gen_control <= pwdata[7:0];
    end
  end

  // Base clock: held still while powered off
  assign base_tick = power_enable_bit & (base_cnt == baud_gen_control);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !power_enable_bit) begin
      base_cnt <= 8'h00;
    end else begin
      base_cnt <= base_tick ? 8'h00 : base_cnt + 8'h01;
    end
  end

  // Enables pass through the base clock before taking effect
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !power_enable_bit) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else if (base_tick) begin
      tx_en_q <= tx_enable_bit;
      rx_en_q <= rx_enable_bit;
    end
  end

  // Receive pin: three stages, a change counts when the last two agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (!power_enable_bit) begin
        rx_line <= 1'b1;
      end else if (rx_s2 == rx_s3) begin
        rx_line <= rx_s3;
      end
    end
  end

  // Transmit data register
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !tx_run) begin
      tx_shift_data <= `ASPC_BUF_RST;
    end else if (tx_wr) begin
      tx_shift_data <= pwdata[7:0];
    end
  end

  // Transmitter sequencer; a write mid-frame restarts it, so software must wait
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !tx_run) begin
      tx_state <= aspc_pkg::TX_IDLE;
      tx_cnt   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= `ASPC_BUF_RST;
    end else if (tx_wr) begin
      tx_state <= aspc_pkg::TX_START;
      tx_cnt   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= pwdata[7:0];
    end else begin
      if (base_tick) begin
        tx_cnt <= tx_cnt + 4'h1;
      end
      if (tx_adv) begin
        case (tx_state)
          aspc_pkg::TX_START: begin
            tx_state <= aspc_pkg::TX_DATA;
          end
          aspc_pkg::TX_DATA: begin
            tx_sh  <= {1'b1, tx_sh[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == last_data_bit) begin
              tx_bit   <= 3'h0;
              tx_state <= par_on ? aspc_pkg::TX_PAR : aspc_pkg::TX_STOP;
            end
          end
          aspc_pkg::TX_PAR: begin
            tx_state <= aspc_pkg::TX_STOP;
          end
          aspc_pkg::TX_STOP: begin
            tx_bit <= 3'h1;
            if (tx_bit[0] || !stop_length_sel) begin
              tx_state <= aspc_pkg::TX_IDLE;
            end
          end
          default: begin
            tx_state <= aspc_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  // Line level per state; parity taken from the loaded character
  wire tx_par_bit = par_bit(tx_shift_data, char_length_sel, parity_sel);
  wire next_out   = (tx_state == aspc_pkg::TX_START) ? 1'b0 :
                    (tx_state == aspc_pkg::TX_DATA)  ? tx_sh[0] :
                    (tx_state == aspc_pkg::TX_PAR)   ? tx_par_bit :
                    1'b1;
  wire tx_end     = tx_adv & (tx_state == aspc_pkg::TX_STOP) &
                    (tx_bit[0] | ~stop_length_sel);

  // Serial output and completion pulse from flip-flops
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_out_pin <= 1'b1;
      tx_done_irq    <= 1'b0;
    end else begin
      serial_out_pin <= tx_run ? next_out : 1'b1;
      tx_done_irq    <= tx_run & tx_end & ~tx_wr;
    end
  end

  // Receiver sequencer; idle looks at level, so a low line at enable starts a frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !rx_run) begin
      rx_state   <= aspc_pkg::RX_IDLE;
      rx_cnt     <= 4'h0;
      rx_bit     <= 3'h0;
      rx_shifter <= 8'h00;
      rx_par     <= 1'b0;
    end else begin
      case (rx_state)
        aspc_pkg::RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (!rx_line) begin
            rx_state <= aspc_pkg::RX_START;
          end
        end
        aspc_pkg::RX_START: begin
          if (base_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
          end
          if (rx_mid) begin
            rx_cnt   <= 4'h0;
            rx_bit   <= 3'h0;
            rx_state <= rx_line ? aspc_pkg::RX_IDLE : aspc_pkg::RX_DATA; // Glitch filter
          end
        end
        aspc_pkg::RX_DATA: begin
          if (base_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
          end
          if (rx_adv) begin
            rx_shifter <= {rx_line, rx_shifter[7:1]};
            rx_bit     <= rx_bit + 3'h1;
            if (rx_bit == last_data_bit) begin
              rx_state <= par_on ? aspc_pkg::RX_PAR : aspc_pkg::RX_STOP;
            end
          end
        end
        aspc_pkg::RX_PAR: begin
          if (base_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
          end
          if (rx_adv) begin
            rx_par   <= rx_line;
            rx_state <= aspc_pkg::RX_STOP;
          end
        end
        aspc_pkg::RX_STOP: begin
          if (base_tick) begin
            rx_cnt <= rx_cnt + 4'h1;
          end
          if (rx_adv) begin
            rx_state <= aspc_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state <= aspc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Holding buffer and its unread marker; a completion beats a same-cycle read
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !power_enable_bit) begin
      rx_holding_buffer <= `ASPC_BUF_RST;
      rx_full           <= 1'b0;
    end else if (rx_done && !overrun) begin
      rx_holding_buffer <= rx_data;
      rx_full           <= 1'b1;
    end else if (rxb_rd) begin
      rx_full <= 1'b0;
    end
  end

  // Error flags: read clears, a new error in the same cycle still lands
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (!power_enable_bit && !rx_enable_bit)) begin
      rx_error_flags <= `ASPC_ERR_RST;
    end else if (!power_enable_bit) begin
      rx_error_flags <= `ASPC_ERR_RST;
    end else begin
      rx_error_flags <= (rx_error_flags & {3{~err_rd}}) | err_set;
    end
  end

  // Receive event pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_done_irq <= 1'b0;
      rx_err_irq  <= 1'b0;
    end else begin
      rx_done_irq <= rx_done & ~overrun;
      rx_err_irq  <= |err_set;
    end
  end

endmodule // aspc_core

// File: tb/aspc_monitor.sv
`timescale 1ns/1ns
`include "aspc_regs.svh"
module aspc_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial pins and pulses
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        tx_done_irq,
  input wire logic        rx_done_irq,
  input wire logic        rx_err_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] mode_q;
  // Access decodes for the mode shadow write and the reads that are judged below
  wire acc     = psel && penable;
  wire wr_mode = acc && pwrite && pstrb[0] && paddr == `ASPC_ADDR_MODE;
  wire rd_mode = acc && !pwrite && paddr == `ASPC_ADDR_MODE;
  wire rd_buf  = acc && !pwrite && paddr == `ASPC_ADDR_RXBUF;
  wire rd_err  = acc && !pwrite && paddr == `ASPC_ADDR_ERR;
  wire rd_tx   = acc && !pwrite && paddr == `ASPC_ADDR_TXDATA;
  // Shadow of the mode register; lets reads be judged per mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      mode_q <= 8'h01;
    else if (wr_mode)
      mode_q <= pwdata[7:0];
  end
  // Power stays off for several cycles, so any frame has been flushed
  sequence s_pw_off;
    !mode_q[7] [*4];
  endsequence
  property p_reset_idle;
    $fell(sys_rst) |-> serial_out_pin && !tx_done_irq && !rx_done_irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line not idle after reset");
  property p_stop_high;
    tx_done_irq |-> $past(serial_out_pin) && $past(serial_out_pin, 8);
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("frame ended without stop");
  property p_tx_reads_zero;
    rd_tx |-> prdata == 32'h0000_0000;
  endproperty
  a_tx_reads_zero: assert property (p_tx_reads_zero) else $error("tx data readable");
  property p_err_upper;
    rd_err |-> prdata[31:3] == 29'h0000_0000;
  endproperty
  a_err_upper: assert property (p_err_upper) else $error("error upper bits set");
  property p_mode_bit0;
    rd_mode |-> prdata[0];
  endproperty
  a_mode_bit0: assert property (p_mode_bit0) else $error("mode bit 0 reads low");
  property p_par_zero;
    rd_err && mode_q[4:3] == 2'h1 |-> !prdata[2];
  endproperty
  a_par_zero: assert property (p_par_zero) else $error("parity flag in zero mode");
  property p_pw_off_idle;
    s_pw_off |-> serial_out_pin && !rx_done_irq;
  endproperty
  a_pw_off_idle: assert property (p_pw_off_idle) else $error("activity while off");
  property p_pw_off_buf;
    rd_buf && !mode_q[7] && $past(mode_q[7], 2) == 1'b0 |-> prdata[7:0] == 8'hFF;
  endproperty
  a_pw_off_buf: assert property (p_pw_off_buf) else $error("buffer not FF while off");
endmodule // aspc_monitor

bind aspc_core aspc_monitor mon_u (
  .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .serial_in_pin, .serial_out_pin, .tx_done_irq, .rx_done_irq,
  .rx_err_irq
);

// File: tb/aspc_remote_station.sv
`timescale 1ns/1ns
module aspc_remote_station #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic sys_clk,
  // Serial lines, named as seen at the core
  input  wire logic serial_out_pin,
  output logic      serial_in_pin
);
  // Idle high, so enabling reception never sees a false start
  initial serial_in_pin = 1'b1;
  // Parity of a character; zero mode always gives 0
  function automatic logic par_of(input logic [7:0] d, input int nd, input logic [1:0] pm);
    logic x;
    x = ^(d & ((nd == 8) ? 8'hFF : 8'h7F));
    return (pm == 2'h1) ? 1'b0 : x ^ (pm == 2'h2);
  endfunction
  // One frame LSB first; faults only when the bench asks for them
  task automatic send(input logic [7:0] d, input int nd, input logic [1:0] pm,
                      input logic bad_par, input logic bad_stop);
    logic q[$];
    q.push_back(1'b0);
    for (int i = 0; i < nd; i++)
      q.push_back(d[i]);
    if (pm != 2'h0)
      q.push_back(par_of(d, nd, pm) ^ bad_par);
    q.push_back(!bad_stop);
    q.push_back(1'b1);
    foreach (q[k]) begin
      @(posedge sys_clk);
      serial_in_pin <= q[k];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  endtask
  // Samples the core's output mid-bit after the start edge
  task automatic recv(input int nd, input logic hp, output logic [7:0] d,
                      output logic p, output logic ok);
    d = 8'h00;
    p = 1'b0;
    while (serial_out_pin !== 1'b0) @(posedge sys_clk);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    ok = (serial_out_pin === 1'b0);
    for (int i = 0; i < nd; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      d[i] = serial_out_pin;
    end
    if (hp) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      p = serial_out_pin;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    ok = ok && (serial_out_pin === 1'b1);
  endtask
endmodule // aspc_remote_station

// File: tb/test_async_serial_port_core.sv
`timescale 1ns/1ns
`include "aspc_regs.svh"
module test_async_serial_port_core;
  logic        sys_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        tx_done_irq;
  logic        rx_done_irq;
  logic        rx_err_irq;
  int          err_total;
  int          check_count;
  int          cyc;
  logic [7:0]  mode_now;
  aspc_core dut_u (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .serial_in_pin, .serial_out_pin, .tx_done_irq, .rx_done_irq,
    .rx_err_irq
  );
  aspc_remote_station peer_u (.sys_clk, .serial_out_pin, .serial_in_pin);
  always #5 sys_clk = ~sys_clk;
  // Watchdog: the run needs far fewer cycles than this
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // An edge passes first, so back-to-back calls never drive twice at once
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    chk("pready_wait", 32'h0, 32'(n));
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(nm, {24'h0, e}, r);
  endtask
  // Disable under the old framing first, then change framing, settle, enable
  task automatic set_mode(input logic [7:0] m);
    wr(`ASPC_ADDR_MODE, mode_now & 8'h9F);
    wr(`ASPC_ADDR_MODE, m & 8'h9F);
    cycles(4);
    wr(`ASPC_ADDR_MODE, m);
    cycles(3);
    mode_now = m;
  endtask
  // Waits for a receive pulse and judges which pulses came: {done, error}
  task automatic wait_rx(input logic [1:0] e);
    int n;
    n = 0;
    while ((rx_done_irq | rx_err_irq) !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    chk("rx_event", 32'h1, 32'(n < 400));
    chk("rx_pulses", 32'(e), 32'({rx_done_irq, rx_err_irq}));
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic er;
    rd_chk("mode", `ASPC_ADDR_MODE, 8'h01);
    rd_chk("err", `ASPC_ADDR_ERR, 8'h00);
    wr(`ASPC_ADDR_RXBUF, 8'h12);
    rd_chk("rxbuf", `ASPC_ADDR_RXBUF, 8'hFF);
    rd_chk("txdata", `ASPC_ADDR_TXDATA, 8'h00);
    apb(1'b0, 32'h0003_FDFC, 32'h0, r, er);
    chk("unmapped", 32'h1, 32'(er));
  endtask
  // Each framing: parity mode, length and stop count, timed to the done pulse
  task automatic t_tx();
    logic [15:0] c [4];
    logic [7:0]  m;
    logic [7:0]  d;
    logic        hp;
    logic        p;
    logic        ok;
    int          nd;
    int          n;
    int          bits;
    c = '{16'h0455, 16'h0EA6, 16'h103C, 16'h1CE1};
    for (int i = 0; i < 4; i++) begin
      m = 8'hC1 | c[i][15:8];
      nd = m[2] ? 8 : 7;
      hp = m[4:3] != 2'h0;
      bits = 2 + nd + 32'(hp) + 32'(m[1]);
      set_mode(m);
      n = 0;
      fork
        peer_u.recv(nd, hp, d, p, ok);
        begin
          wr(`ASPC_ADDR_TXDATA, c[i][7:0]);
          while (tx_done_irq !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            n++;
          end
        end
      join
      chk("tx_data", 32'(c[i][7:0] & (m[2] ? 8'hFF : 8'h7F)), 32'(d));
      chk("tx_par", 32'(peer_u.par_of(c[i][7:0], nd, m[4:3])), 32'(p));
      chk("tx_frame", 32'h1, 32'(ok));
      chk("tx_len", 32'h1, 32'(n >= 16 * bits && n <= 16 * bits + 6));
    end
  endtask
  // Fields: mode bits, data, bad parity, bad stop, expected flags
  task automatic t_rx();
    logic [31:0] c [5];
    logic [7:0]  m;
    c = '{32'h04A5_0000, 32'h18C3_0000, 32'h145A_1004, 32'h0C5A_1000, 32'h040F_0102};
    for (int i = 0; i < 5; i++) begin
      m = 8'hA1 | c[i][31:24];
      set_mode(m);
      fork
        peer_u.send(c[i][23:16], m[2] ? 8 : 7, m[4:3], c[i][12], c[i][8]);
        wait_rx({1'b1, c[i][7:0] != 8'h00});
      join
      rd_chk("rx_err", `ASPC_ADDR_ERR, c[i][7:0]);
      rd_chk("rx_err_clr", `ASPC_ADDR_ERR, 8'h00);
      rd_chk("rx_buf", `ASPC_ADDR_RXBUF, c[i][23:16] & (m[2] ? 8'hFF : 8'h7F));
    end
    // Second character arrives before the first is read
    for (int i = 0; i < 2; i++) begin
      fork
        peer_u.send(8'h11 * (i + 1), 8, 2'h0, 1'b0, 1'b0);
        wait_rx({i == 0, i == 1});
      join
    end
    rd_chk("ovr_err", `ASPC_ADDR_ERR, 8'h01);
    rd_chk("ovr_buf", `ASPC_ADDR_RXBUF, 8'h11);
  endtask
  // Leave a flag and a character behind, then power down
  task automatic t_power_off();
    fork
      peer_u.send(8'h44, 8, 2'h0, 1'b0, 1'b1);
      wait_rx(2'h3);
    join
    set_mode(8'h81);
    wr(`ASPC_ADDR_MODE, 8'h01);
    cycles(3);
    wr(`ASPC_ADDR_TXDATA, 8'h00);
    cycles(20);
    chk("off_line", 32'h1, 32'(serial_out_pin));
    rd_chk("off_buf", `ASPC_ADDR_RXBUF, 8'hFF);
    rd_chk("off_err", `ASPC_ADDR_ERR, 8'h00);
  endtask
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    mode_now = 8'h01;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs();
    wr(`ASPC_ADDR_BAUD, 8'h00);
    t_tx();
    t_rx();
    t_power_off();
    conclude();
  end
endmodule // test_async_serial_port_core
